// >>> ais_pkg.sv
// Package for the analog input scaler: widths, ranges, defaults, modes.
// Assumes signed 16-bit samples in 0.01 percent steps.
package ais_pkg;

  localparam int unsigned DATA_W     = 16;
  localparam int unsigned PROD_W     = 32;
  localparam logic signed [15:0] FULL_POS   = 16'sh2710;  // 10000
  localparam logic signed [15:0] FULL_NEG   = -16'sh2710; // -10000
  // Voltage defaults: 1000/1000, offset 0
  localparam logic signed [15:0] VOLT_NUM_RST = 16'sh03E8;
  localparam logic signed [15:0] VOLT_DEN_RST = 16'sh03E8;
  localparam logic signed [15:0] VOLT_OFS_RST = 16'sh0000;
  // Current defaults: 1250/1000, offset 2000 (20 percent)
  localparam logic signed [15:0] CURR_NUM_RST = 16'sh04E2;
  localparam logic signed [15:0] CURR_DEN_RST = 16'sh03E8;
  localparam logic signed [15:0] CURR_OFS_RST = 16'sh07D0;
  localparam int unsigned DIV_CYCLES = 34;

  typedef enum logic [1:0] {
    AIS_IDLE = 2'b00,
    AIS_MUL  = 2'b01,
    AIS_DIV  = 2'b10,
    AIS_DONE = 2'b11
  } ais_state_t;

  typedef enum logic {
    AIS_SIMPLE_SCALING = 1'b0,
    AIS_LINEAR_EQUATION_SCALING = 1'b1
  } ais_mode_t;

endpackage

// >>> ais_divider.sv
// Sequential signed divider, restoring, one quotient bit per cycle.
// Assumes a nonzero divisor; the caller screens zero.
module ais_divider (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        start_in,
  input  wire logic [31:0] dividend_in,
  input  wire logic [15:0] divisor_in,
  output logic             done_out,
  output logic [31:0]      quotient_out
);

  logic [31:0] quo_reg, quo_next;
  logic [31:0] rem_reg, rem_next;
  logic [31:0] den_reg, den_next;
  logic [5:0]  cnt_reg, cnt_next;
  logic        neg_reg, neg_next;
  logic        busy_reg, busy_next;
  logic        done_reg, done_next;
  logic [32:0] trial;

  always_comb begin
    quo_next  = quo_reg;
    rem_next  = rem_reg;
    den_next  = den_reg;
    cnt_next  = cnt_reg;
    neg_next  = neg_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    trial     = {rem_reg, quo_reg[31]} - {1'b0, den_reg};
    if (start_in && !busy_reg) begin
      // Work on magnitudes, fix the sign at the end
      quo_next  = dividend_in[31] ? 32'(-dividend_in) : dividend_in;
      den_next  = divisor_in[15] ? 32'(-{{16{divisor_in[15]}}, divisor_in})
                                 : {16'h0000, divisor_in};
      neg_next  = dividend_in[31] ^ divisor_in[15];
      rem_next  = 32'h0000_0000;
      cnt_next  = 6'h20;
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (cnt_reg == 6'h00) begin
        busy_next = 1'b0;
        done_next = 1'b1;
        if (neg_reg) begin
          quo_next = 32'(-quo_reg);
        end
      end else begin
        if (!trial[32]) begin
          rem_next = trial[31:0];
          quo_next = {quo_reg[30:0], 1'b1};
        end else begin
          rem_next = {rem_reg[30:0], quo_reg[31]};
          quo_next = {quo_reg[30:0], 1'b0};
        end
        cnt_next = cnt_reg - 6'h01;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quo_reg  <= 32'h0000_0000;
      rem_reg  <= 32'h0000_0000;
      den_reg  <= 32'h0000_0000;
      cnt_reg  <= 6'h00;
      neg_reg  <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      quo_reg  <= quo_next;
      rem_reg  <= rem_next;
      den_reg  <= den_next;
      cnt_reg  <= cnt_next;
      neg_reg  <= neg_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign done_out     = done_reg;
  assign quotient_out = quo_reg;

endmodule

// >>> ais_scaler.sv
// Analog input scaler: turns a raw input sample into a scaled percentage.
// Assumes samples arrive from logic on mclk_in with a one-cycle strobe.
// Summary of operation
// - Two modes: simple scaling after reset, free linear equation scaling.
// - Equation mode result is numerator/denominator times (sample minus offset).
// - Numerator and denominator are signed, -10000 to 10000; ratio is gain.
// - Offset is signed, -10000 to 10000 in 0.01 percent, subtracted first.
// - Per-input voltage or current choice; current switches the shunt in.
// - Current defaults: 1250/1000 gain, offset 2000 for 4 to 20 mA.
// - Mode changes only from terminal path; reload defaults after switching back.
module ais_scaler (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        sample_valid_in,
  input  wire logic [15:0] sample_in,
  input  wire logic        terminal_mode_wr_in,
  input  wire logic        terminal_mode_in,
  input  wire logic        param_wr_in,
  input  wire logic [15:0] param_num_in,
  input  wire logic [15:0] param_den_in,
  input  wire logic [15:0] param_ofs_in,
  input  wire logic        param_current_in,
  input  wire logic        load_defaults_in,
  output logic             mode_out,
  output logic             shunt_en_out,
  output logic             busy_out,
  output logic             result_valid_out,
  output logic [15:0]      result_out,
  output logic             div_zero_out
);

  logic        rst_sync1_reg, rst_sync2_reg;
  logic        rst_n;
  ais_pkg::ais_state_t state_reg, state_next;
  ais_pkg::ais_mode_t  mode_reg, mode_next;
  logic signed [15:0] num_reg, num_next;
  logic signed [15:0] den_reg, den_next;
  logic signed [15:0] ofs_reg, ofs_next;
  logic        cur_reg, cur_next;
  logic signed [31:0] prod_reg, prod_next;
  logic signed [16:0] diff_reg, diff_next;
  logic signed [15:0] res_reg, res_next;
  logic        vld_reg, vld_next;
  logic        dz_reg, dz_next;
  logic        div_start;
  logic        div_done;
  logic [31:0] div_quo;
  logic signed [31:0] quo_s;

  // Async assert, synchronous release
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  assign rst_n = rst_sync2_reg;

  function automatic logic signed [15:0] clip(input logic signed [15:0] v);
    if (v > ais_pkg::FULL_POS) begin
      clip = ais_pkg::FULL_POS;
    end else if (v < ais_pkg::FULL_NEG) begin
      clip = ais_pkg::FULL_NEG;
    end else begin
      clip = v;
    end
  endfunction

  // Parameter and mode state
  always_comb begin
    mode_next = mode_reg;
    num_next  = num_reg;
    den_next  = den_reg;
    ofs_next  = ofs_reg;
    cur_next  = cur_reg;
    if (terminal_mode_wr_in) begin
      mode_next = ais_pkg::ais_mode_t'(terminal_mode_in);
    end
    if (load_defaults_in) begin
      // Defaults follow the current input choice
      if (cur_reg) begin
        num_next = ais_pkg::CURR_NUM_RST;
        den_next = ais_pkg::CURR_DEN_RST;
        ofs_next = ais_pkg::CURR_OFS_RST;
      end else begin
        num_next = ais_pkg::VOLT_NUM_RST;
        den_next = ais_pkg::VOLT_DEN_RST;
        ofs_next = ais_pkg::VOLT_OFS_RST;
      end
    end else if (param_wr_in && state_reg == ais_pkg::AIS_IDLE) begin
      num_next = clip(param_num_in);
      den_next = clip(param_den_in);
      ofs_next = clip(param_ofs_in);
      cur_next = param_current_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= ais_pkg::AIS_SIMPLE_SCALING;
      num_reg  <= ais_pkg::VOLT_NUM_RST;
      den_reg  <= ais_pkg::VOLT_DEN_RST;
      ofs_reg  <= ais_pkg::VOLT_OFS_RST;
      cur_reg  <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      num_reg  <= num_next;
      den_reg  <= den_next;
      ofs_reg  <= ofs_next;
      cur_reg  <= cur_next;
    end
  end

  assign quo_s = $signed(div_quo);

  // Datapath sequencer
  always_comb begin
    state_next = state_reg;
    prod_next  = prod_reg;
    diff_next  = diff_reg;
    res_next   = res_reg;
    vld_next   = 1'b0;
    dz_next    = dz_reg;
    div_start  = 1'b0;
    case (state_reg)
      ais_pkg::AIS_IDLE: begin
        if (sample_valid_in) begin
          if (mode_reg == ais_pkg::AIS_SIMPLE_SCALING) begin
            // Simple mode passes the clipped sample through
            res_next = clip(sample_in);
            vld_next = 1'b1;
          end else begin
            // 17 bits hold any difference of two 16-bit values
            diff_next  = 17'(signed'(sample_in)) - 17'(ofs_reg);
            state_next = ais_pkg::AIS_MUL;
          end
        end
      end
      ais_pkg::AIS_MUL: begin
        prod_next = 32'(diff_reg * num_reg);
        if (den_reg == 16'sh0000) begin
          dz_next    = 1'b1;
          vld_next   = 1'b1;
          state_next = ais_pkg::AIS_IDLE;
        end else begin
          state_next = ais_pkg::AIS_DIV;
        end
      end
      ais_pkg::AIS_DIV: begin
        // Start drops with done, else the divider reloads its quotient
        div_start = !div_done;
        if (div_done) begin
          state_next = ais_pkg::AIS_DONE;
        end
      end
      ais_pkg::AIS_DONE: begin
        // Saturate the wide quotient to full scale
        if (quo_s > 32'(ais_pkg::FULL_POS)) begin
          res_next = ais_pkg::FULL_POS;
        end else if (quo_s < 32'(ais_pkg::FULL_NEG)) begin
          res_next = ais_pkg::FULL_NEG;
        end else begin
          res_next = quo_s[15:0];
        end
        // Zero flag only moves with the result strobe
        dz_next    = 1'b0;
        vld_next   = 1'b1;
        state_next = ais_pkg::AIS_IDLE;
      end
      default: begin
        state_next = ais_pkg::AIS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ais_pkg::AIS_IDLE;
      prod_reg  <= 32'sh0000_0000;
      diff_reg  <= 17'sh0_0000;
      res_reg   <= 16'sh0000;
      vld_reg   <= 1'b0;
      dz_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      prod_reg  <= prod_next;
      diff_reg  <= diff_next;
      res_reg   <= res_next;
      vld_reg   <= vld_next;
      dz_reg    <= dz_next;
    end
  end

  // Division is slow but small; one sample in flight at a time
  ais_divider u_div (
    .clk_in       (mclk_in),
    .rst_n_in     (rst_n),
    .start_in     (div_start),
    .dividend_in  (prod_reg),
    .divisor_in   (den_reg),
    .done_out     (div_done),
    .quotient_out (div_quo)
  );

  assign mode_out         = mode_reg;
  assign shunt_en_out     = cur_reg;
  assign busy_out         = (state_reg != ais_pkg::AIS_IDLE);
  assign result_valid_out = vld_reg;
  assign result_out       = res_reg;
  assign div_zero_out     = dz_reg;

endmodule

// >>> ais_scaler_props.sv
// Checker for the scaler's port timing and value behaviour.
// Assumes one clock domain; sees only the ais_scaler ports.
module ais_scaler_props (
  input wire logic        mclk_in,
  input wire logic        rst_n_in,
  input wire logic        sample_valid_in,
  input wire logic [15:0] sample_in,
  input wire logic        terminal_mode_wr_in,
  input wire logic        terminal_mode_in,
  input wire logic        param_wr_in,
  input wire logic        param_current_in,
  input wire logic        load_defaults_in,
  input wire logic        mode_out,
  input wire logic        shunt_en_out,
  input wire logic        busy_out,
  input wire logic        result_valid_out,
  input wire logic [15:0] result_out,
  input wire logic        div_zero_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  logic signed [15:0] clip_s;
  assign clip_s = $signed(sample_in) > ais_pkg::FULL_POS ? ais_pkg::FULL_POS
    : $signed(sample_in) < ais_pkg::FULL_NEG ? ais_pkg::FULL_NEG : sample_in;
  sequence s_take;
    sample_valid_in && !busy_out;
  endsequence
  sequence s_eq;
    s_take ##0 mode_out;
  endsequence
  property p_simple;
    s_take ##0 !mode_out |=> result_valid_out && result_out == $past(clip_s);
  endproperty
  property p_eq;
    s_eq |=> busy_out ##[1:60] result_valid_out;
  endproperty
  property p_range;
    $signed(result_out) <= ais_pkg::FULL_POS &&
      $signed(result_out) >= ais_pkg::FULL_NEG;
  endproperty
  property p_stand;
    !result_valid_out |-> $stable(result_out) && $stable(div_zero_out);
  endproperty
  property p_hold;
    result_valid_out && div_zero_out |-> $stable(result_out);
  endproperty
  property p_shunt;
    param_wr_in && !load_defaults_in && !busy_out
      |=> shunt_en_out == $past(param_current_in);
  endproperty
  property p_dflt;
    load_defaults_in |=> $stable(shunt_en_out);
  endproperty
  property p_mode_wr;
    terminal_mode_wr_in |=> mode_out == $past(terminal_mode_in);
  endproperty
  property p_mode_hold;
    !terminal_mode_wr_in |=> $stable(mode_out);
  endproperty
  a_simple: assert property (p_simple)
    else $error("simple result wrong");
  a_eq: assert property (p_eq)
    else $error("equation result late");
  a_range: assert property (p_range)
    else $error("result out of range");
  a_stand: assert property (p_stand)
    else $error("result changed without strobe");
  a_hold: assert property (p_hold)
    else $error("zero divisor did not hold");
  a_shunt: assert property (p_shunt)
    else $error("shunt select wrong");
  a_dflt: assert property (p_dflt)
    else $error("default load moved shunt");
  a_mode_wr: assert property (p_mode_wr)
    else $error("mode write lost");
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode changed without write");
endmodule
bind ais_scaler ais_scaler_props u_props (
  .mclk_in             (mclk_in),
  .rst_n_in            (rst_n_in),
  .sample_valid_in     (sample_valid_in),
  .sample_in           (sample_in),
  .terminal_mode_wr_in (terminal_mode_wr_in),
  .terminal_mode_in    (terminal_mode_in),
  .param_wr_in         (param_wr_in),
  .param_current_in    (param_current_in),
  .load_defaults_in    (load_defaults_in),
  .mode_out            (mode_out),
  .shunt_en_out        (shunt_en_out),
  .busy_out            (busy_out),
  .result_valid_out    (result_valid_out),
  .result_out          (result_out),
  .div_zero_out        (div_zero_out)
);

// >>> ais_sig_src.sv
// Analog signal source model feeding samples to the scaler.
// Assumes the bench calls send on a falling clock edge.
module ais_sig_src (
  input  wire logic        mclk_in,
  input  wire logic        busy_in,
  output logic             valid_out,
  output logic [15:0]      sample_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    valid_out = 1'b0;
    sample_out = 16'h0000;
  end
  // Strobe stays up when another send follows at once
  task automatic send(input logic [15:0] x, input bit lst);
    while (busy_in) @(negedge mclk_in);
    valid_out = 1'b1;
    sample_out = x;
    @(negedge mclk_in);
    if (lst) begin
      valid_out = 1'b0;
      sample_out = ~x; // Stale data is not held
    end
  endtask
endmodule

// >>> ais_scaler_tb_top.sv
// Self-checking bench for the analog input scaler.
// Assumes ais_pkg, ais_scaler, ais_sig_src and the checker compiled.
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  err_total++; $display("wrong value %0t: got %h exp %h", $time, a, b); end end
module ais_scaler_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sv, twr, tmd, pwr, pcur, ldef, mode, shunt, busy, rv, dz;
  logic [15:0] smp, pn, pd, po, res;
  logic [15:0] last = 16'h0000;
  logic [17:0] exp_q[$];
  int          err_total, samples_checked, num, den, ofs, md;
  ais_scaler dut (.mclk_in(clk), .rst_n_in(rst_n), .sample_valid_in(sv),
    .sample_in(smp), .terminal_mode_wr_in(twr), .terminal_mode_in(tmd),
    .param_wr_in(pwr), .param_num_in(pn), .param_den_in(pd),
    .param_ofs_in(po), .param_current_in(pcur), .load_defaults_in(ldef),
    .mode_out(mode), .shunt_en_out(shunt), .busy_out(busy),
    .result_valid_out(rv), .result_out(res), .div_zero_out(dz));
  ais_sig_src src (.mclk_in(clk), .busy_in(busy), .valid_out(sv),
    .sample_out(smp));
  always #10 clk = ~clk;
  function automatic logic [17:0] calc(input logic [15:0] x);
    int v;
    v = $signed(x);
    if (md == 1 && den == 0) return {2'b11, last};
    if (md == 1) v = num * (v - ofs) / den;
    if (v > ais_pkg::FULL_POS) v = ais_pkg::FULL_POS;
    if (v < ais_pkg::FULL_NEG) v = ais_pkg::FULL_NEG;
    last = v[15:0];
    return {md[0], 1'b0, last};
  endfunction
  task automatic go(input logic [15:0] x, input bit lst);
    exp_q.push_back(calc(x));
    src.send(x, lst);
  endtask
  task automatic par(input int a, b, c, input bit cur, upd);
    // Writes meant to land wait out a busy datapath
    if (upd) while (busy) @(negedge clk);
    pn = a[15:0];
    pd = b[15:0];
    po = c[15:0];
    pcur = cur;
    pwr = 1'b1;
    @(negedge clk);
    pwr = 1'b0;
    if (upd) begin
      num = a;
      den = b;
      ofs = c;
    end
  endtask
  task automatic ld(input bit cur);
    // Defaults follow the registered input choice, so set it first
    par(0, 0, 0, cur, 1'b0);
    ldef = 1'b1;
    @(negedge clk);
    ldef = 1'b0;
    num = cur ? ais_pkg::CURR_NUM_RST : ais_pkg::VOLT_NUM_RST;
    den = cur ? ais_pkg::CURR_DEN_RST : ais_pkg::VOLT_DEN_RST;
    ofs = cur ? ais_pkg::CURR_OFS_RST : ais_pkg::VOLT_OFS_RST;
    `CHK(shunt, cur)
  endtask
  task automatic setm(input bit m);
    tmd = m;
    twr = 1'b1;
    @(negedge clk);
    twr = 1'b0;
    md = m;
    `CHK(mode, m)
  endtask
  task automatic drain;
    repeat (100) if (exp_q.size() != 0) @(negedge clk);
    @(negedge clk);
    `CHK(exp_q.size(), 0)
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(negedge clk) if (rv === 1'b1) begin : mon
    logic [17:0] e;
    `CHK(exp_q.size() != 0, 1'b1)
    e = exp_q.pop_front();
    `CHK(res, e[15:0])
    if (e[17]) `CHK(dz, e[16])
  end
  initial begin
    #400000;
    err_total++;
    conclude;
  end
  initial begin
    logic [15:0] tv[4] = '{16'h4000, 16'hC000, 16'h1234, 16'hD8F0};
    int tn[3] = '{16'h03E8, 16'h04E2, 16'h03E8};
    int td[3] = '{16'h03E8, 16'h03E8, 16'h0190};
    int to[3] = '{16'h0000, 16'h03E8, 16'h01F4};
    logic [15:0] tt[3] = '{16'h2710, 16'h2328, 16'h1194};
    int r = 32'h0000_2710;
    void'($urandom(32'heab8_7cf6));
    {twr, tmd, pwr, pcur, ldef} = '0;
    {pn, pd, po} = '0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(mode, 1'b0)
    foreach (tv[i]) go(tv[i], i == 3);
    drain;
    setm(1'b1);
    for (int i = 0; i < 3; i++) begin
      par(tn[i], td[i], to[i], 1'b0, 1'b1);
      go(to[i][15:0], 1'b1);
      go(tt[i], 1'b1);
      go(16'hF448, 1'b1);
      drain;
    end
    ld(1'b1);
    go(16'h07D0, 1'b1);
    go(16'h2710, 1'b1);
    go(16'h1770, 1'b1);
    go(16'h0FA0, 1'b1);
    par(16'h0001, 16'h0001, 16'h0000, 1'b1, 1'b0);
    drain;
    go(16'h0FA0, 1'b1);
    par(16'h01F4, 16'h0000, 16'h0000, 1'b1, 1'b1);
    go(16'h0BB8, 1'b1);
    drain;
    repeat (20) begin
      par($urandom_range(2 * r) - r, $urandom_range(2 * r) - r,
        $urandom_range(2 * r) - r, 1'($urandom_range(1)), 1'b1);
      go($urandom_range(2 * r) - r, 1'b1);
      drain;
    end
    setm(1'b0);
    ld(1'b0);
    go(16'hB1E0, 1'b1);
    drain;
    conclude;
  end
endmodule
